// *** vpsf_pkg.sv ***
// Shared constants and types of the video pattern stream flow shell
package vpsf_pkg;

   // ==========================================================================
   // Widths and depths
   // ==========================================================================
   localparam int unsigned PIX_W     = 24;   // Pixel data width
   localparam int unsigned BUF_DEPTH = 2;    // Entries in the pixel buffer
   localparam int unsigned PTR_W     = 1;    // Index width of the buffer
   localparam int unsigned EXT_IRQ_W = 6;    // Width of the external irq bundle

   // ==========================================================================
   // Counts and limits
   // ==========================================================================
   localparam logic [2:0] FLUSH_CYCLES = 3'h7;  // Input pause after a line end
   localparam logic [2:0] FLUSH_NONE   = 3'h0;
   localparam logic [2:0] FLUSH_LAST   = 3'h1;
   localparam logic [1:0] OCC_EMPTY    = 2'h0;
   localparam logic [1:0] OCC_FULL     = 2'h2;  // Buffer occupancy when full

   // ==========================================================================
   // Carriers
   // ==========================================================================
   typedef struct packed {
      logic [PIX_W-1:0] data;
      logic             sof;   // Start of frame marker
      logic             eol;   // End of line marker
   } vpsf_pixel_type;

   localparam vpsf_pixel_type PIXEL_RST = '0;

   // ==========================================================================
   // Flow states
   // ==========================================================================
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_STREAM = 3'b010,
      ST_FLUSH  = 3'b100
   } vpsf_state_type;

endpackage

// *** vpsf_buf.sv ***
// Two-entry pixel buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module vpsf_buf (
   input  wire logic                    i_core_clk,
   input  wire logic                    i_reset,
   input  wire logic                    i_push,
   input  wire vpsf_pkg::vpsf_pixel_type i_pix,
   output logic                         o_in_ready,
   input  wire logic                    i_pop,
   output logic                         o_out_valid,
   output vpsf_pkg::vpsf_pixel_type     o_pix
);

   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed {
      vpsf_pkg::vpsf_pixel_type [vpsf_pkg::BUF_DEPTH-1:0] mem;
      logic [vpsf_pkg::PTR_W-1:0]                         wr_ptr;
      logic [vpsf_pkg::PTR_W-1:0]                         rd_ptr;
      logic [1:0]                                         count;
   } vpsf_buf_state_type;

   vpsf_buf_state_type q;
   vpsf_buf_state_type n;
   logic               do_push;
   logic               do_pop;

   // Honest full and empty from the count
   assign o_in_ready  = (q.count != vpsf_pkg::OCC_FULL);
   assign o_out_valid = (q.count != vpsf_pkg::OCC_EMPTY);
   assign o_pix       = q.mem[q.rd_ptr];

   // Next state of storage and pointers
   always_comb begin
      n       = q;
      do_push = i_push && o_in_ready;
      do_pop  = i_pop && o_out_valid;
      for (int e = 0; e < vpsf_pkg::BUF_DEPTH; e++) begin
         if (do_push && (q.wr_ptr == e[vpsf_pkg::PTR_W-1:0])) begin
            n.mem[e] = i_pix;
         end
      end
      if (do_push) begin
         n.wr_ptr = q.wr_ptr + 1'b1;
      end
      if (do_pop) begin
         n.rd_ptr = q.rd_ptr + 1'b1;
      end
      n.count = 2'(q.count + {1'b0, do_push} - {1'b0, do_pop});
   end

   // State register
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

endmodule // vpsf_buf
`default_nettype wire

// *** vpsf_sync_edge.sv ***
// Frame sync edge detector and active video sampler
`timescale 1ns/1ps
`default_nettype none
module vpsf_sync_edge (
   input  wire logic i_core_clk,
   input  wire logic i_reset,
   input  wire logic i_clk_en,
   input  wire logic i_vsync,
   input  wire logic i_active_video,
   output logic      o_vsync_rise,
   output logic      o_active
);

   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed {
      logic vs;
      logic rise;
      logic act;
   } vpsf_edge_state_type;

   vpsf_edge_state_type q;
   vpsf_edge_state_type n;

   assign o_vsync_rise = q.rise;
   assign o_active     = q.act;

   // Rising edge of vertical sync, frozen when disabled
   always_comb begin
      n = q;
      if (i_clk_en) begin
         n.vs   = i_vsync;
         n.rise = i_vsync && !q.vs;
         n.act  = i_active_video;
      end
   end

   // State register
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

endmodule // vpsf_sync_edge
`default_nettype wire

// *** vpsf_stream_flow.sv ***
// Streaming flow-control shell of the video pattern generator
//
// Function
// - Both pixel ports follow the stream protocol
// - Output valid drops once buffers run empty
// - Input ready drops once buffers fill
// - One pixel in, one out per cycle
// - Seven-cycle input pause after each line end
// - No control port; irq held low in every build
// - External irq bundle held low in every build
// - Blanking and hsync inputs present but ignored
// - Vertical sync serves as frame reference
// - Active video input marks valid video
// - Transfer needs ready, valid, enable, reset released
// - Enable low freezes everything; reset still acts
// - Start of frame on first pixel only
// - End of line on last pixel only
`timescale 1ns/1ps
`default_nettype none
module vpsf_stream_flow #(
   parameter bit HAS_CTRL_PORT = 1'b0,  // No control port; o_irq held low either way
   parameter bit HAS_EXT_IRQ   = 1'b0,  // External irq bundle held low either way
   parameter bit HAS_TIMING    = 1'b1   // Let vertical sync arm start of frame
) (
   input  wire logic                            i_core_clk,
   input  wire logic                            i_reset,
   input  wire logic                            i_clk_en,
   input  wire logic [vpsf_pkg::PIX_W-1:0]      i_s_axis_video_tdata,
   input  wire logic                            i_s_axis_video_tvalid,
   input  wire logic                            i_s_axis_video_tuser,
   input  wire logic                            i_s_axis_video_tlast,
   output logic                                 o_s_axis_video_tready,
   output logic [vpsf_pkg::PIX_W-1:0]           o_m_axis_video_tdata,
   output logic                                 o_m_axis_video_tvalid,
   input  wire logic                            i_m_axis_video_tready,
   output logic                                 o_m_axis_video_tuser,
   output logic                                 o_m_axis_video_tlast,
   input  wire logic                            i_hblank,
   input  wire logic                            i_hsync,
   input  wire logic                            i_vblank,
   input  wire logic                            i_vsync,
   input  wire logic                            i_active_video,
   output logic                                 o_irq,
   output logic [vpsf_pkg::EXT_IRQ_W-1:0]       o_ext_irq_ctrl_bundle
);

   // ==========================================================================
   // State of the shell
   // ==========================================================================
   typedef struct packed {
      vpsf_pkg::vpsf_state_type           state;
      logic [2:0]                         flush_cnt;   // Cycles of pause left
      logic [1:0]                         occ;         // Words held in buffer
      logic                               s_ready;     // Registered input ready
      logic                               m_valid;     // Output register full
      vpsf_pkg::vpsf_pixel_type           m_pix;       // Output register word
      logic                               sof_arm;     // Frame sync seen
      logic                               irq;
      logic [vpsf_pkg::EXT_IRQ_W-1:0]     ext_irq;
   } vpsf_top_state_type;

   localparam vpsf_top_state_type TOP_RST = '{
      state:     vpsf_pkg::ST_IDLE,
      flush_cnt: vpsf_pkg::FLUSH_NONE,
      occ:       vpsf_pkg::OCC_EMPTY,
      s_ready:   1'b0,
      m_valid:   1'b0,
      m_pix:     vpsf_pkg::PIXEL_RST,
      sof_arm:   1'b0,
      irq:       1'b0,
      ext_irq:   '0
   };

   vpsf_top_state_type       q;
   vpsf_top_state_type       n;

   // ==========================================================================
   // Internal nets
   // ==========================================================================
   logic                     in_take;      // Input transfer this cycle
   logic                     out_take;     // Output transfer this cycle
   logic                     buf_push;
   logic                     buf_pop;
   logic                     buf_in_ready;
   logic                     buf_out_valid;
   vpsf_pkg::vpsf_pixel_type buf_out_pix;
   vpsf_pkg::vpsf_pixel_type in_pix;
   logic                     vs_rise;
   logic                     active_q;
   logic                     unused_timing;

   // ==========================================================================
   // Outputs, each straight from the state register
   // ==========================================================================
   // stream signals driven from flops
   assign o_s_axis_video_tready = q.s_ready;
   assign o_m_axis_video_tvalid = q.m_valid;
   assign o_m_axis_video_tdata  = q.m_pix.data;
   assign o_m_axis_video_tuser  = q.m_pix.sof;
   assign o_m_axis_video_tlast  = q.m_pix.eol;
   assign o_irq                 = q.irq;
   assign o_ext_irq_ctrl_bundle = q.ext_irq;

   assign unused_timing = i_hblank ^ i_hsync ^ i_vblank;

   // ==========================================================================
   // Transfer qualifiers
   // ==========================================================================
   // handshake with enable and reset
   assign in_take  = i_clk_en && !i_reset && i_s_axis_video_tvalid && q.s_ready
                     && buf_in_ready;
   assign out_take = i_clk_en && !i_reset && q.m_valid && i_m_axis_video_tready;

   // Buffer moves words into the output register when it is free or leaving
   assign buf_push = in_take;
   assign buf_pop  = i_clk_en && buf_out_valid && (!q.m_valid || i_m_axis_video_tready);

   // start of frame from input or armed frame sync
   always_comb begin
      in_pix      = vpsf_pkg::PIXEL_RST;
      in_pix.data = i_s_axis_video_tdata;
      in_pix.sof  = i_s_axis_video_tuser || (q.sof_arm && active_q);
      // end of line passes with its pixel
      in_pix.eol  = i_s_axis_video_tlast;
   end

   // ==========================================================================
   // Frame sync detection
   // ==========================================================================
   // Vertical sync rising edge and sampled active video
   vpsf_sync_edge u_sync_edge (
      .i_core_clk     (i_core_clk),
      .i_reset        (i_reset),
      .i_clk_en       (i_clk_en),
      .i_vsync        (i_vsync),
      .i_active_video (i_active_video),
      .o_vsync_rise   (vs_rise),
      .o_active       (active_q)
   );

   // ==========================================================================
   // Pixel buffer
   // ==========================================================================
   // Two words of slack between input and output register
   vpsf_buf u_buf (
      .i_core_clk  (i_core_clk),
      .i_reset     (i_reset),
      .i_push      (buf_push),
      .i_pix       (in_pix),
      .o_in_ready  (buf_in_ready),
      .i_pop       (buf_pop),
      .o_out_valid (buf_out_valid),
      .o_pix       (buf_out_pix)
   );

   // ==========================================================================
   // Next state
   // ==========================================================================
   always_comb begin
      n = q;

      if (buf_pop) begin
         n.m_valid = 1'b1;
         n.m_pix   = buf_out_pix;
      end else if (out_take) begin
         n.m_valid = 1'b0;
      end

      // Mirror of buffer occupancy for the ready decision
      n.occ = 2'(q.occ + {1'b0, buf_push} - {1'b0, buf_pop});

      // vertical sync arms start of frame
      if (HAS_TIMING && vs_rise) begin
         n.sof_arm = 1'b1;
      end else if (in_take && q.sof_arm && active_q) begin
         // arm consumed only in active video
         n.sof_arm = 1'b0;
      end

      // Flow state and flush counter
      case (q.state)
         vpsf_pkg::ST_IDLE: begin
            n.state = vpsf_pkg::ST_STREAM;
         end
         vpsf_pkg::ST_STREAM: begin
            if (in_take && i_s_axis_video_tlast) begin
               n.state     = vpsf_pkg::ST_FLUSH;
               n.flush_cnt = vpsf_pkg::FLUSH_CYCLES;
            end
         end
         vpsf_pkg::ST_FLUSH: begin
            n.flush_cnt = q.flush_cnt - 3'h1;
            if (q.flush_cnt == vpsf_pkg::FLUSH_LAST) begin
               n.state = vpsf_pkg::ST_STREAM;
            end
         end
         default: begin
            n.state     = vpsf_pkg::ST_IDLE;
            n.flush_cnt = vpsf_pkg::FLUSH_NONE;
         end
      endcase

      // ready only while a slot stays free
      n.s_ready = (n.state == vpsf_pkg::ST_STREAM) && (n.occ != vpsf_pkg::OCC_FULL);

      n.irq = HAS_CTRL_PORT && 1'b0;
      // external irq bundle absent, held low
      n.ext_irq = HAS_EXT_IRQ ? '0 : '0;

      if (!i_clk_en) begin
         n = q;
      end
   end

   // ==========================================================================
   // State register
   // ==========================================================================
   // reset acts even when enable is low
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         q <= TOP_RST;
      end else begin
         q <= n;
      end
   end

endmodule // vpsf_stream_flow
`default_nettype wire

// *** vpsf_checker.sv ***
// Stream protocol checker for the flow shell
`timescale 1ns/1ps
`default_nettype none
module vpsf_checker (
   input wire logic                             i_core_clk,
   input wire logic                             i_reset,
   input wire logic                             i_clk_en,
   input wire logic                             i_s_axis_video_tvalid,
   input wire logic                             i_s_axis_video_tlast,
   input wire logic                             o_s_axis_video_tready,
   input wire logic [vpsf_pkg::PIX_W-1:0]       o_m_axis_video_tdata,
   input wire logic                             o_m_axis_video_tvalid,
   input wire logic                             i_m_axis_video_tready,
   input wire logic                             o_m_axis_video_tuser,
   input wire logic                             o_m_axis_video_tlast,
   input wire logic                             o_irq,
   input wire logic [vpsf_pkg::EXT_IRQ_W-1:0]   o_ext_irq_ctrl_bundle
);
   // ==========================================================================
   // Transfer qualifiers
   // ==========================================================================
   logic in_x;
   logic out_x;
   assign in_x  = i_s_axis_video_tvalid & o_s_axis_video_tready & i_clk_en;
   assign out_x = o_m_axis_video_tvalid & i_m_axis_video_tready & i_clk_en;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   // ==========================================================================
   // Assertions
   // ==========================================================================
   chk_flush_pause: assert property (
      in_x && i_s_axis_video_tlast |=> !o_s_axis_video_tready [*7])
      else $error("input ready high inside flush");
   chk_freeze_all: assert property (
      !i_clk_en |=> $stable({o_s_axis_video_tready, o_m_axis_video_tdata,
         o_m_axis_video_tvalid, o_m_axis_video_tuser, o_m_axis_video_tlast}))
      else $error("outputs moved with enable low");
   chk_reset_idle: assert property (
      $fell(i_reset) |-> !o_s_axis_video_tready && !o_m_axis_video_tvalid)
      else $error("ready or valid set out of reset");
   chk_out_hold: assert property (
      o_m_axis_video_tvalid && !i_m_axis_video_tready && i_clk_en |=>
      o_m_axis_video_tvalid && $stable({o_m_axis_video_tdata,
         o_m_axis_video_tuser, o_m_axis_video_tlast}))
      else $error("output word changed before taken");
   chk_irq_quiet: assert property (
      o_irq == 1'b0 && o_ext_irq_ctrl_bundle == '0)
      else $error("irq outputs not idle");
   chk_full_rate: assert property (
      in_x && !i_s_axis_video_tlast && out_x |=> o_s_axis_video_tready)
      else $error("input ready dropped at full rate");
   chk_drain_stop: assert property (
      (!i_s_axis_video_tvalid && i_m_axis_video_tready && i_clk_en) [*5]
      |=> !o_m_axis_video_tvalid)
      else $error("output valid with buffers empty");
   chk_fill_stop: assert property (
      (in_x && !i_m_axis_video_tready) [*3] |=> !o_s_axis_video_tready)
      else $error("input ready with buffers full");

   // Main scenarios reached
   cov_flush: cover property (in_x && i_s_axis_video_tlast);
   cov_stall: cover property (o_m_axis_video_tvalid && !i_m_axis_video_tready);
   cov_freeze: cover property (!i_clk_en && o_m_axis_video_tvalid);
endmodule // vpsf_checker

bind vpsf_stream_flow vpsf_checker chk_u (.i_core_clk(i_core_clk), .i_reset(i_reset),
   .i_clk_en(i_clk_en), .i_s_axis_video_tvalid(i_s_axis_video_tvalid),
   .i_s_axis_video_tlast(i_s_axis_video_tlast),
   .o_s_axis_video_tready(o_s_axis_video_tready),
   .o_m_axis_video_tdata(o_m_axis_video_tdata),
   .o_m_axis_video_tvalid(o_m_axis_video_tvalid),
   .i_m_axis_video_tready(i_m_axis_video_tready),
   .o_m_axis_video_tuser(o_m_axis_video_tuser),
   .o_m_axis_video_tlast(o_m_axis_video_tlast), .o_irq(o_irq),
   .o_ext_irq_ctrl_bundle(o_ext_irq_ctrl_bundle));
`default_nettype wire

// *** vpsf_sink.sv ***
// Downstream video sink model with prompt, slow and stopped modes
`timescale 1ns/1ps
`default_nettype none
module vpsf_sink (
   input  wire logic       i_core_clk,
   input  wire logic       i_reset,
   input  wire logic [1:0] i_mode,        // 0 prompt, 1 slow, 2 stopped
   output logic            o_ready = 1'b0
);
   always @(posedge i_core_clk) begin
      if (i_reset) o_ready <= 1'b0;
      else o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && $urandom % 3 == 0);
   end
endmodule // vpsf_sink
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the stream flow shell
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0, rst = 1'b1, en = 1'b1, sv = 1'b0, su = 1'b0, sl = 1'b0, rnd = 1'b0;
   logic [vpsf_pkg::PIX_W-1:0] sd = '0, md;
   logic [3:0] tim = '0;                  // Blanking, sync, active video
   logic [1:0] mode = 2'h0;
   logic vs = 1'b0, act_on = 1'b0, ins = 1'b0;  // Frame sync, forced active, tuser held off
   logic tr, mv, mu, ml, mr, irq;
   logic [vpsf_pkg::EXT_IRQ_W-1:0] bun;
   int errors = 0, checked = 0, cyc = 0, t0;
   vpsf_pkg::vpsf_pixel_type exp_q[$];

   always #5 clk = ~clk;

   vpsf_stream_flow dut_u (.i_core_clk(clk), .i_reset(rst), .i_clk_en(en),
      .i_s_axis_video_tdata(sd), .i_s_axis_video_tvalid(sv), .i_s_axis_video_tuser(su),
      .i_s_axis_video_tlast(sl), .o_s_axis_video_tready(tr), .o_m_axis_video_tdata(md),
      .o_m_axis_video_tvalid(mv), .i_m_axis_video_tready(mr), .o_m_axis_video_tuser(mu),
      .o_m_axis_video_tlast(ml), .i_hblank(tim[0]), .i_hsync(tim[1]), .i_vblank(tim[2]),
      .i_vsync(vs), .i_active_video(tim[3] | act_on),
      .o_irq(irq), .o_ext_irq_ctrl_bundle(bun));
   vpsf_sink sink_u (.i_core_clk(clk), .i_reset(rst), .i_mode(mode), .o_ready(mr));

   // ignored inputs toggle, enable random, timeout
   always @(posedge clk) begin
      tim <= 4'($urandom);
      if (rnd) en <= ($urandom % 6 != 0);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         final_report();
      end
   end

   // Scoreboard on every output transfer
   always @(posedge clk) begin
      if (!rst && en && mv === 1'b1 && mr === 1'b1) begin
         if (exp_q.size() == 0) check(1'b0, "output word never sent");
         else check({md, mu, ml} === exp_q.pop_front(), "pixel mismatch");
      end
   end

   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   function automatic vpsf_pkg::vpsf_pixel_type pix(input int n, input int i, input logic f);
      pix = '{data: 24'($urandom), sof: f && i == 0, eol: i == n - 1};
   endfunction

   // Offer one pixel and hold it until taken
   task automatic put(input vpsf_pkg::vpsf_pixel_type p);
      exp_q.push_back(p);
      sv <= 1'b1;
      sd <= p.data;
      su <= p.sof & !ins;
      sl <= p.eol;
      do @(posedge clk); while (!(tr === 1'b1 && en === 1'b1));
   endtask

   task automatic line(input int n, input logic f, input logic gaps);
      for (int i = 0; i < n; i++) begin
         put(pix(n, i, f));
         if (gaps && $urandom % 3 == 0) begin
            sv <= 1'b0;
            @(posedge clk);
         end
      end
      sv <= 1'b0;
      @(posedge clk);
   endtask

   task automatic drain();
      repeat (200) if (exp_q.size() != 0) @(posedge clk);
      check(exp_q.size() == 0, "words left in flight");
   endtask

   task automatic final_report();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      void'($urandom(32'hcfab));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check(tr === 1'b0 && mv === 1'b0, "busy out of reset");
      @(posedge clk);
      t0 = cyc;
      line(16, 1'b1, 1'b0);
      check(cyc - t0 == 17, "not one pixel per cycle");
      rnd <= 1'b1;
      for (int k = 0; k < 30; k++) begin
         mode <= 2'($urandom % 2);
         line(1 + $urandom % 9, k % 4 == 0, 1'b1);
      end
      mode <= 2'h2;
      fork
         line(8, 1'b1, 1'b0);
         begin
            repeat (15) @(posedge clk);
            check(tr === 1'b0, "input not throttled");
            mode <= 2'h0;
         end
      join
      drain();
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      line(5, 1'b1, 1'b1);
      drain();
      // Start of frame from vertical sync alone, input tuser held low
      ins <= 1'b1;
      act_on <= 1'b1;
      vs <= 1'b1;
      repeat (6) @(posedge clk);
      vs <= 1'b0;
      @(posedge clk);
      line(3, 1'b1, 1'b0);
      drain();
      ins <= 1'b0;
      act_on <= 1'b0;
      check(irq === 1'b0 && bun === '0, "irq outputs active");
      final_report();
   end
endmodule // testbench
`default_nettype wire
